//--- rtl/acr_regs.svh
// Register offsets, field positions and reset values for the channel setup
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_ADDR_W 8
`define ACR_OFS_INPUT_SETUP 8'h3C
`define ACR_OFS_GAIN 8'h3D
`define ACR_OFS_VOLUME 8'h3E
`define ACR_OFS_GAIN_TRIM 8'h3F

`define ACR_RST_INPUT_SETUP 8'h00
`define ACR_RST_GAIN 8'h00
`define ACR_RST_VOLUME 8'hC9
`define ACR_RST_GAIN_TRIM 8'h80

`define ACR_KIND_BIT 7
`define ACR_SRC_MSB 6
`define ACR_SRC_LSB 5
`define ACR_DC_BIT 4
`define ACR_IMP_MSB 3
`define ACR_IMP_LSB 2
`define ACR_ENH_BIT 0
`define ACR_GAIN_MSB 7
`define ACR_GAIN_LSB 2
`define ACR_TRIM_MSB 7
`define ACR_TRIM_LSB 4

`define ACR_MASK_INPUT_SETUP 8'hFD
`define ACR_MASK_GAIN 8'hFC
`define ACR_MASK_VOLUME 8'hFF
`define ACR_MASK_GAIN_TRIM 8'hF0

`define ACR_VOL_MUTE_CODE 8'h00
`define ACR_VOL_UNITY_CODE 9'h0C9
`define ACR_TRIM_UNITY_CODE 5'h08

`endif

//--- rtl/acr_pkg.sv
// Types shared by the channel setup registers
package acr_pkg;

   typedef enum logic [1:0]
   {
      ACR_SRC_ANALOG_DIFF = 2'h0,
      ACR_SRC_ANALOG_SINGLE = 2'h1,
      ACR_SRC_DENSITY_MOD = 2'h2,
      ACR_SRC_RESERVED = 2'h3
   } acr_src_t;

   typedef enum logic [1:0]
   {
      ACR_IMP_2K5 = 2'h0,
      ACR_IMP_10K = 2'h1,
      ACR_IMP_20K = 2'h2,
      ACR_IMP_RESERVED = 2'h3
   } acr_imp_t;

endpackage : acr_pkg

//--- rtl/acr_channel_regs.sv
// Configuration registers and decoded controls for one capture channel
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs.svh"

// Behaviour
// - Bit 7: 0 microphone, 1 line input
// - Bits 6-5 select differential, single-ended, density-mod
// - Bit 4 AC/DC coupling, analog only
// - Bits 3-2 impedance 2.5k/10k/20k, analog only
// - Bit 0 enables enhancer or gain loop
// - Gain code equals dB, 0 to 42
// - Volume code zero mutes output
// - Volume codes 1-255 in half-dB steps
// - Volume resets to code 201, 0 dB
// - Trim register resets to 80h
// - Trim code in 0.1 dB steps, 8 unity
module acr_channel_regs
(
   // Clock, reset, enable
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // Register access port
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [`ACR_ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wr_data,
   output logic [7:0] o_reg_rd_data,
   output logic o_reg_rd_valid,
   // Enhancer mode bit from the shared mode register
   input wire logic i_enhancer_mode_agc,
   // Analog front end controls
   output logic o_chan_input_kind_sel,
   output acr_pkg::acr_src_t o_chan_input_source_sel,
   output logic o_chan_analog_active,
   output logic o_chan_coupling_sel,
   output acr_pkg::acr_imp_t o_chan_input_impedance_sel,
   output logic [5:0] o_chan_analog_gain_code,
   // Dynamics controls
   output logic o_range_enhancer_en,
   output logic o_automatic_gain_loop_en,
   // Digital gain stage controls
   output logic o_chan_mute,
   output logic signed [8:0] o_volume_half_db,
   output logic signed [4:0] o_gain_trim_tenth_db
);
   import acr_pkg::*;

   logic [7:0] input_setup_q;
   logic [7:0] input_setup_d;
   logic [7:0] gain_q;
   logic [7:0] gain_d;
   logic [7:0] volume_q;
   logic [7:0] volume_d;
   logic [7:0] trim_q;
   logic [7:0] trim_d;
   logic [7:0] rd_data_q;
   logic [7:0] rd_data_d;
   logic rd_valid_q;
   logic rd_valid_d;

   logic kind_q;
   logic kind_d;
   acr_src_t src_q;
   acr_src_t src_d;
   logic analog_q;
   logic analog_d;
   logic dc_q;
   logic dc_d;
   acr_imp_t imp_q;
   acr_imp_t imp_d;
   logic [5:0] again_q;
   logic [5:0] again_d;
   logic enh_q;
   logic enh_d;
   logic agc_q;
   logic agc_d;
   logic mute_q;
   logic mute_d;
   logic signed [8:0] vol_q;
   logic signed [8:0] vol_d;
   logic signed [4:0] trim_db_q;
   logic signed [4:0] trim_db_d;

   // Address decode, one hit per mapped register
   logic hit_input_setup;
   logic hit_gain;
   logic hit_volume;
   logic hit_trim;
   logic hit_any;
   logic wr_take;
   logic rd_take;

   always_comb
   begin
      hit_input_setup = (i_reg_addr == `ACR_OFS_INPUT_SETUP);
      hit_gain = (i_reg_addr == `ACR_OFS_GAIN);
      hit_volume = (i_reg_addr == `ACR_OFS_VOLUME);
      hit_trim = (i_reg_addr == `ACR_OFS_GAIN_TRIM);
      hit_any = hit_input_setup | hit_gain | hit_volume | hit_trim;
      // Unmapped writes are dropped here
      wr_take = i_reg_wr_en & hit_any;
      rd_take = i_reg_rd_en;
   end

   // Configuration register writes; reserved bits never stored
   always_comb
   begin
      input_setup_d = input_setup_q;
      gain_d = gain_q;
      volume_d = volume_q;
      trim_d = trim_q;
      if (wr_take)
      begin
         if (hit_input_setup)
         begin
            input_setup_d = i_reg_wr_data &
                            `ACR_MASK_INPUT_SETUP;
         end
         if (hit_gain)
         begin
            gain_d = i_reg_wr_data & `ACR_MASK_GAIN;
         end
         if (hit_volume)
         begin
            volume_d = i_reg_wr_data & `ACR_MASK_VOLUME;
         end
         if (hit_trim)
         begin
            trim_d = i_reg_wr_data & `ACR_MASK_GAIN_TRIM;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         input_setup_q <= `ACR_RST_INPUT_SETUP;
         gain_q <= `ACR_RST_GAIN;
         volume_q <= `ACR_RST_VOLUME;
         trim_q <= `ACR_RST_GAIN_TRIM;
      end
      else if (i_clk_en)
      begin
         input_setup_q <= input_setup_d;
         gain_q <= gain_d;
         volume_q <= volume_d;
         trim_q <= trim_d;
      end
   end

   // Read port: addressed register, zero when unmapped
   always_comb
   begin
      rd_data_d = rd_data_q;
      rd_valid_d = 1'b0;
      if (rd_take)
      begin
         rd_valid_d = 1'b1;
         // Reserved bits are already zero in storage
         if (hit_input_setup)
         begin
            rd_data_d = input_setup_q;
         end
         else if (hit_gain)
         begin
            rd_data_d = gain_q;
         end
         else if (hit_volume)
         begin
            rd_data_d = volume_q;
         end
         else if (hit_trim)
         begin
            rd_data_d = trim_q;
         end
         else
         begin
            rd_data_d = 8'h00;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   // Decoding of fields into front end controls
   always_comb
   begin
      kind_d = input_setup_q[`ACR_KIND_BIT];
      case (input_setup_q[`ACR_SRC_MSB:`ACR_SRC_LSB])
         2'h0: src_d = ACR_SRC_ANALOG_DIFF;
         2'h1: src_d = ACR_SRC_ANALOG_SINGLE;
         2'h2: src_d = ACR_SRC_DENSITY_MOD;
         default: src_d = ACR_SRC_RESERVED;
      endcase
      case (src_d)
         ACR_SRC_ANALOG_DIFF: analog_d = 1'b1;
         ACR_SRC_ANALOG_SINGLE: analog_d = 1'b1;
         default: analog_d = 1'b0;
      endcase
      // Coupling and impedance only reach the pins for analog sources
      dc_d = analog_d & input_setup_q[`ACR_DC_BIT];
      imp_d = ACR_IMP_2K5;
      if (analog_d)
      begin
         case (input_setup_q[`ACR_IMP_MSB:`ACR_IMP_LSB])
            2'h0: imp_d = ACR_IMP_2K5;
            2'h1: imp_d = ACR_IMP_10K;
            2'h2: imp_d = ACR_IMP_20K;
            default: imp_d = ACR_IMP_RESERVED;
         endcase
      end
      again_d = gain_q[`ACR_GAIN_MSB:`ACR_GAIN_LSB];
      enh_d = input_setup_q[`ACR_ENH_BIT] & ~i_enhancer_mode_agc;
      agc_d = input_setup_q[`ACR_ENH_BIT] & i_enhancer_mode_agc;
   end

   // Gain stage values: half-dB volume and tenth-dB trim
   always_comb
   begin
      mute_d = (volume_q == `ACR_VOL_MUTE_CODE);
      if (mute_d)
      begin
         vol_d = 9'sh000;
      end
      else
      begin
         // Half-dB steps relative to the unity code
         vol_d = $signed({1'b0, volume_q} -
                 `ACR_VOL_UNITY_CODE);
      end
      trim_db_d = $signed({1'b0, trim_q[`ACR_TRIM_MSB:`ACR_TRIM_LSB]} -
                  `ACR_TRIM_UNITY_CODE);
   end

   // Outputs follow the registers one cycle later; reset values match
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         kind_q <= 1'b0;
         src_q <= ACR_SRC_ANALOG_DIFF;
         analog_q <= 1'b1;
         dc_q <= 1'b0;
         imp_q <= ACR_IMP_2K5;
         again_q <= 6'h00;
         enh_q <= 1'b0;
         agc_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         kind_q <= kind_d;
         src_q <= src_d;
         analog_q <= analog_d;
         dc_q <= dc_d;
         imp_q <= imp_d;
         again_q <= again_d;
         enh_q <= enh_d;
         agc_q <= agc_d;
      end
   end

   // Gain stage outputs
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         mute_q <= 1'b0;
         vol_q <= 9'sh000;
         trim_db_q <= 5'sh00;
      end
      else if (i_clk_en)
      begin
         mute_q <= mute_d;
         vol_q <= vol_d;
         trim_db_q <= trim_db_d;
      end
   end

   assign o_reg_rd_data = rd_data_q;
   assign o_reg_rd_valid = rd_valid_q;
   assign o_chan_input_kind_sel = kind_q;
   assign o_chan_input_source_sel = src_q;
   assign o_chan_analog_active = analog_q;
   assign o_chan_coupling_sel = dc_q;
   assign o_chan_input_impedance_sel = imp_q;
   assign o_chan_analog_gain_code = again_q;
   assign o_range_enhancer_en = enh_q;
   assign o_automatic_gain_loop_en = agc_q;
   assign o_chan_mute = mute_q;
   assign o_volume_half_db = vol_q;
   assign o_gain_trim_tenth_db = trim_db_q;

endmodule : acr_channel_regs
`default_nettype wire

//--- verif/acr_channel_regs_props.sv
// Concurrent checks on the channel setup register ports
`timescale 1ns/1ps
`default_nettype none
module acr_channel_regs_props
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Register port
   input wire logic i_clk_en,
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wr_data,
   input wire logic o_reg_rd_valid,
   input wire logic i_enhancer_mode_agc,
   // Decoded controls
   input wire logic o_chan_input_kind_sel,
   input wire logic o_chan_analog_active,
   input wire logic o_chan_coupling_sel,
   input wire acr_pkg::acr_imp_t o_chan_input_impedance_sel,
   input wire logic [5:0] o_chan_analog_gain_code,
   input wire logic o_range_enhancer_en,
   input wire logic o_automatic_gain_loop_en,
   input wire logic o_chan_mute,
   input wire logic signed [8:0] o_volume_half_db,
   input wire logic signed [4:0] o_gain_trim_tenth_db
);
   import acr_pkg::*;
   logic wv;
   assign wv = i_clk_en && i_reg_wr_en;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   kind_write_a: assert property (
      wv && i_reg_addr == 8'h3C ##1 i_clk_en |=>
      o_chan_input_kind_sel == $past(i_reg_wr_data[7], 2)) else $error("kind");
   gain_write_a: assert property (
      wv && i_reg_addr == 8'h3D ##1 i_clk_en |=> o_chan_analog_gain_code ==
      $past(i_reg_wr_data[7:2], 2)) else $error("gain code");
   vol_write_a: assert property (
      wv && i_reg_addr == 8'h3E && i_reg_wr_data != 8'h00 ##1 i_clk_en |=>
      o_volume_half_db == $signed({1'b0, $past(i_reg_wr_data, 2)}) - 9'sh0C9)
      else $error("volume");
   vol_mute_a: assert property (
      wv && i_reg_addr == 8'h3E && i_reg_wr_data == 8'h00 ##1 i_clk_en |=>
      o_chan_mute && o_volume_half_db == 9'sh000) else $error("mute");
   trim_write_a: assert property (
      wv && i_reg_addr == 8'h3F ##1 i_clk_en |=> o_gain_trim_tenth_db ==
      $signed({1'b0, $past(i_reg_wr_data[7:4], 2)}) - 5'sh08) else $error("trim");
   analog_gate_a: assert property (
      !o_chan_analog_active |-> !o_chan_coupling_sel &&
      o_chan_input_impedance_sel == ACR_IMP_2K5) else $error("analog gating");
   enh_mode_a: assert property (
      i_clk_en |=> !(o_range_enhancer_en && $past(i_enhancer_mode_agc)) &&
      !(o_automatic_gain_loop_en && !$past(i_enhancer_mode_agc)))
      else $error("enhancer mode");
   rd_pulse_a: assert property (
      i_clk_en |=> o_reg_rd_valid == $past(i_reg_rd_en)) else $error("read valid");
endmodule : acr_channel_regs_props
bind acr_channel_regs acr_channel_regs_props i_props (.*);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the channel setup registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import acr_pkg::*;
   logic i_ref_clk, i_reset_n, i_clk_en, i_reg_wr_en, i_reg_rd_en;
   logic i_enhancer_mode_agc, o_reg_rd_valid, o_chan_input_kind_sel;
   logic o_chan_analog_active, o_chan_coupling_sel, o_chan_mute;
   logic o_range_enhancer_en, o_automatic_gain_loop_en;
   logic [7:0] i_reg_addr, i_reg_wr_data, o_reg_rd_data;
   acr_src_t o_chan_input_source_sel;
   acr_imp_t o_chan_input_impedance_sel;
   logic [5:0] o_chan_analog_gain_code;
   logic signed [8:0] o_volume_half_db;
   logic signed [4:0] o_gain_trim_tenth_db;
   logic [7:0] m [4];
   logic [7:0] mk [4] = '{8'hFD, 8'hFC, 8'hFF, 8'hF0};
   logic [15:0] dv [12] = '{16'h3C00, 16'h3C21, 16'h3C19, 16'h3C5B, 16'h3C35,
      16'h3DA8, 16'h3E00, 16'h3E01, 16'h3EFF, 16'h3F00, 16'h3FFF, 16'h3BAA};
   int n_mismatch, n_tests;
   acr_channel_regs i_dut (.*);
   task chk(input logic [15:0] s, e);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, d);
      i_reg_wr_en = 1;
      i_reg_addr = a;
      i_reg_wr_data = d;
      @(posedge i_ref_clk);
      #1 i_reg_wr_en = 0;
      if (i_clk_en && a[7:2] == 6'h0F)
         m[a[1:0]] = d & mk[a[1:0]];
   endtask : wr
   task rd(input logic [7:0] a);
      i_reg_rd_en = 1;
      i_reg_addr = a;
      @(posedge i_ref_clk);
      #1 i_reg_rd_en = 0;
      chk(o_reg_rd_valid, 1);
      chk(o_reg_rd_data,
         a[7:2] == 6'h0F ? m[a[1:0]] : 8'h00);
   endtask : rd
   task outs;
      logic [7:0] c;
      logic an, g;
      c = m[0];
      an = !c[6];
      g = i_enhancer_mode_agc;
      @(posedge i_ref_clk);
      #1 chk(o_chan_input_kind_sel, c[7]);
      chk(o_chan_input_source_sel, c[6:5]);
      chk(o_chan_analog_active, an);
      chk(o_chan_coupling_sel, an & c[4]);
      chk(o_chan_input_impedance_sel, an ? c[3:2] : 2'h0);
      chk(o_chan_analog_gain_code, m[1][7:2]);
      chk({o_range_enhancer_en, o_automatic_gain_loop_en},
         {c[0] & !g, c[0] & g});
      chk(o_chan_mute, m[2] == 8'h00);
      chk($unsigned(o_volume_half_db), m[2] == 8'h00 ? 9'h000 :
         9'({1'b0, m[2]} - 9'h0C9));
      chk($unsigned(o_gain_trim_tenth_db),
         5'({1'b0, m[3][7:4]} - 5'h08));
   endtask : outs
   task end_of_test;
      $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial
   begin
      i_ref_clk = 0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   initial
   begin
      #20000;
      n_mismatch++;
      end_of_test;
   end
   initial
   begin
      {i_reset_n, i_clk_en, i_reg_wr_en, i_reg_rd_en, i_enhancer_mode_agc} = 5'h00;
      i_reg_addr = 8'h00;
      i_reg_wr_data = 8'h00;
      m = '{8'h00, 8'h00, 8'hC9, 8'h80};
      void'($urandom(32'h91C5));
      repeat (5) @(posedge i_ref_clk);
      #1 i_reset_n = 1;
      i_clk_en = 1;
      for (int a = 8'h3B; a < 8'h41; a++)
         rd(8'(a));
      outs;
      $display("Reset value test done");
      for (int i = 0; i < 72; i++)
      begin
         logic [7:0] a;
         logic [7:0] d;
         a = i < 12 ? dv[i][15:8] : 8'h3B + 8'($urandom % 6);
         d = i < 12 ? dv[i][7:0] : 8'($urandom);
         if (a == 8'h3C && d[6:5] == 2'h3)
            d[6] = 1'b0;
         if (a == 8'h3C && d[3:2] == 2'h3)
            d[3] = 1'b0;
         if (a == 8'h3D && d[7:2] > 6'h2A)
            d[7:2] = 6'(d[7:2] - 6'h15);
         i_enhancer_mode_agc = 1'($urandom);
         // Reserved source and impedance codes and gain codes above 42 are steered away above
         wr(a, d);
         rd(a);
         outs;
      end
      $display("Write and decode test done");
      i_clk_en = 0;
      wr(8'h3E, 8'h55);
      i_clk_en = 1;
      rd(8'h3E);
      outs;
      $display("Clock enable test done");
      wr(8'h3F, 8'h30);
      i_reset_n = 0;
      m = '{8'h00, 8'h00, 8'hC9, 8'h80};
      repeat (2) @(posedge i_ref_clk);
      #1 i_reset_n = 1;
      for (int a = 8'h3C; a < 8'h40; a++)
         rd(8'(a));
      outs;
      $display("Mid-run reset test done");
      end_of_test;
   end
endmodule : tb_top
`default_nettype wire
